// ===== design/priority_crossbar_port_io.sv
// Purpose: Crossbar routing and output control for four 8-bit ports
// Assumes: Pins are asynchronous; peripherals share mclk
// Notes:   Pin outputs and peripheral inputs are registered
//
// The plain strobed port and the address map are this design's own decisions.
`default_nettype none
module priority_crossbar_port_io #(
   parameter int NPIN = xbar_pkg::NPIN,
   parameter int NSIG = xbar_pkg::NSIG
) (
   // Clock and reset
   input  wire logic               mclk,
   input  wire logic               resetn,
   // Register port
   input  wire xbar_pkg::bus_req_s bus,
   output logic [7:0]              rdata,
   // Peripheral side
   input  wire logic [NSIG-1:0]    periph_out,
   input  wire logic [NSIG-1:0]    periph_oe,
   input  wire logic               ser0_mode0,
   input  wire logic               ser1_mode0,
   output logic [NSIG-1:0]         periph_in,
   // Pins
   input  wire logic [NPIN-1:0]    pin_in,
   output logic [NPIN-1:0]         pin_out,
   output logic [NPIN-1:0]         pin_oe
);
   logic [7:0]           route_r [4];
   logic [7:0]           lat_r   [4];
   logic [7:0]           mode_r  [4];
   logic [7:0]           din1_r;
   logic [7:0]           din2_r;
   logic [NPIN-1:0]      pin_s1_r;
   logic [NPIN-1:0]      pin_s2_r;
   logic [NSIG-1:0]      sig_en;
   logic [NPIN-1:0]      skip;
   logic [NPIN-1:0]      pin_alloc;
   logic [NPIN-1:0][4:0] pin_sig;
   logic [NSIG-1:0]      sig_ok;
   logic [NSIG-1:0][4:0] sig_pin;
   logic [NPIN-1:0]      out_nxt;
   logic [NPIN-1:0]      oe_nxt;
   logic [NPIN-1:0]      lat_flat;
   logic [NPIN-1:0]      mode_flat;
   logic [NPIN-1:0]      pin_rd;
   logic                 glob_en;

   // Byte write, or single-bit write from wdata bit 0
   function automatic logic [7:0] wr_val(input logic [7:0] old,
                                         input xbar_pkg::bus_req_s r);
      logic [7:0] v;
      v = old;
      if (r.bit_we)
         v[r.bit_sel] = r.wdata[0];
      else
         v = r.wdata;
      return v;
   endfunction

   function automatic logic wr_hit(input xbar_pkg::bus_req_s r,
                                   input logic [3:0] off);
      return (r.we || r.bit_we) && r.addr == off;
   endfunction

   assign glob_en = route_r[2][xbar_pkg::B_GLOB_EN];
   assign lat_flat = {lat_r[3], lat_r[2], lat_r[1], lat_r[0]};
   assign mode_flat = {mode_r[3], mode_r[2], mode_r[1], mode_r[0]};
   // Analog pins read as 0
   assign pin_rd = pin_s2_r & {8'hFF, din2_r, din1_r, 8'hFF};
   assign skip = {8'h00, ~din2_r, ~din1_r, 8'h00};

   // Configuration registers
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         for (int i = 0; i < 4; i++)
            route_r[i] <= xbar_pkg::RST_ROUTE;
         din1_r <= xbar_pkg::RST_DIN;
         din2_r <= xbar_pkg::RST_DIN;
      end
      else
      begin
         for (int i = 0; i < 4; i++)
            if (wr_hit(bus, xbar_pkg::OFF_ROUTE0 + 4'(i)))
               route_r[i] <= wr_val(route_r[i], bus);
         if (wr_hit(bus, xbar_pkg::OFF_DIN1))
            din1_r <= wr_val(din1_r, bus);
         if (wr_hit(bus, xbar_pkg::OFF_DIN2))
            din2_r <= wr_val(din2_r, bus);
      end
   end

   // Port latches always store; allocated pins just ignore them
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         for (int i = 0; i < 4; i++)
            lat_r[i] <= xbar_pkg::RST_PORT;
      else
         for (int i = 0; i < 4; i++)
            if (wr_hit(bus, xbar_pkg::OFF_PORT0 + 4'(i)))
               lat_r[i] <= wr_val(lat_r[i], bus);
   end

   // Output mode registers
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         for (int i = 0; i < 4; i++)
            mode_r[i] <= xbar_pkg::RST_MODE;
      else
         for (int i = 0; i < 4; i++)
            if (wr_hit(bus, xbar_pkg::OFF_MODE0 + 4'(i)))
               mode_r[i] <= wr_val(mode_r[i], bus);
   end

   // Read data, one cycle after the strobe
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         rdata <= 8'h00;
      else if (bus.re)
      begin
         unique case (bus.addr)
            4'h0, 4'h1, 4'h2, 4'h3:
               rdata <= route_r[bus.addr[1:0]];
            4'h4, 4'h5, 4'h6, 4'h7:
               if (bus.rmw)
                  rdata <= lat_r[bus.addr[1:0]];
               else
                  rdata <= pin_rd[8*bus.addr[1:0] +: 8];
            4'h8, 4'h9, 4'hA, 4'hB:
               rdata <= mode_r[bus.addr[1:0]];
            4'hC:
               rdata <= din1_r;
            4'hD:
               rdata <= din2_r;
            default:
               rdata <= 8'h00;
         endcase
      end
      else
         rdata <= 8'h00;
   end

   // Pin synchroniser
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
      end
      else
      begin
         pin_s1_r <= pin_in;
         pin_s2_r <= pin_s1_r;
      end
   end

   // Signal enables from route fields; grouped peripherals share one bit, except the PCA count and the 4-wire slave select
   always_comb
   begin
      sig_en = '0;
      sig_en[xbar_pkg::S_SER0_TX] = route_r[0][xbar_pkg::B_SER0_EN];
      sig_en[xbar_pkg::S_SER0_RX] = route_r[0][xbar_pkg::B_SER0_EN];
      sig_en[xbar_pkg::S_SPI_SCK] = route_r[0][xbar_pkg::B_SPI_EN];
      sig_en[xbar_pkg::S_SPI_MISO] = route_r[0][xbar_pkg::B_SPI_EN];
      sig_en[xbar_pkg::S_SPI_MOSI] = route_r[0][xbar_pkg::B_SPI_EN];
      sig_en[xbar_pkg::S_SPI_SEL] = route_r[0][xbar_pkg::B_SPI_EN]
                                  & route_r[3][xbar_pkg::B_SPI4W];
      sig_en[xbar_pkg::S_SMB_DAT] = route_r[0][xbar_pkg::B_SMB_EN];
      sig_en[xbar_pkg::S_SMB_CLK] = route_r[0][xbar_pkg::B_SMB_EN];
      sig_en[xbar_pkg::S_SER1_TX] = route_r[2][xbar_pkg::B_SER1_EN];
      sig_en[xbar_pkg::S_SER1_RX] = route_r[2][xbar_pkg::B_SER1_EN];
      for (int i = 0; i < 6; i++)
         sig_en[xbar_pkg::S_PCA0 + i] =
            route_r[0][xbar_pkg::B_PCA_LO +: 3] > 3'(i);
      sig_en[xbar_pkg::S_ECI]  = route_r[0][xbar_pkg::B_ECI_EN];
      sig_en[xbar_pkg::S_CMP0] = route_r[0][xbar_pkg::B_CMP0_EN];
      sig_en[xbar_pkg::S_CMP1] = route_r[1][xbar_pkg::B_CMP1_EN];
      sig_en[xbar_pkg::S_CMP2] = route_r[3][xbar_pkg::B_CMP2_EN];
      sig_en[xbar_pkg::S_TM0]  = route_r[1][xbar_pkg::B_TM0_EN];
      sig_en[xbar_pkg::S_IRQ0] = route_r[1][xbar_pkg::B_IRQ0_EN];
      sig_en[xbar_pkg::S_TM1]  = route_r[1][xbar_pkg::B_TM1_EN];
      sig_en[xbar_pkg::S_IRQ1] = route_r[1][xbar_pkg::B_IRQ1_EN];
      sig_en[xbar_pkg::S_TM2]  = route_r[1][xbar_pkg::B_TM2_EN];
      sig_en[xbar_pkg::S_TM2X] = route_r[1][xbar_pkg::B_TM2X_EN];
      sig_en[xbar_pkg::S_TM3]  = route_r[3][xbar_pkg::B_TM3_EN];
      sig_en[xbar_pkg::S_TM3X] = route_r[3][xbar_pkg::B_TM3X_EN];
      sig_en[xbar_pkg::S_TM4]  = route_r[2][xbar_pkg::B_TM4_EN];
      sig_en[xbar_pkg::S_TM4X] = route_r[2][xbar_pkg::B_TM4X_EN];
      sig_en[xbar_pkg::S_CLKO] = route_r[1][xbar_pkg::B_CLKO_EN];
      sig_en[xbar_pkg::S_CNV]  = route_r[3][xbar_pkg::B_CNV_EN];
   end

   pin_allocator #(
      .NPIN (NPIN),
      .NSIG (NSIG)
   ) u_alloc (
      .mclk      (mclk),
      .resetn    (resetn),
      .sig_en    (sig_en),
      .skip      (skip),
      .pin_alloc (pin_alloc),
      .pin_sig   (pin_sig),
      .sig_ok    (sig_ok),
      .sig_pin   (sig_pin)
   );

   // Per-pin driver: value, direction and drive type
   always_comb
   begin
      logic [4:0] s;
      logic       val;
      logic       dir;
      logic       od;
      logic       rx_m0;
      s = '0;
      val = 1'b0;
      dir = 1'b0;
      od = 1'b1;
      rx_m0 = 1'b0;
      out_nxt = '0;
      oe_nxt = '0;
      for (int p = 0; p < NPIN; p++)
      begin
         s = pin_sig[p];
         od = ~mode_flat[p];
         if (pin_alloc[p])
         begin
            // In mode 0 the receive pin carries data both ways, so it may pull low
            rx_m0 = (s == 5'(xbar_pkg::S_SER0_RX) && ser0_mode0)
                  | (s == 5'(xbar_pkg::S_SER1_RX) && ser1_mode0);
            val = periph_out[s];
            dir = periph_oe[s] & (~xbar_pkg::INPUT_ONLY[s] | rx_m0);
            od = od | xbar_pkg::FORCE_OD[s] | rx_m0;
         end
         else
         begin
            val = lat_flat[p];
            dir = 1'b1;
         end
         out_nxt[p] = val;
         oe_nxt[p] = glob_en & dir & (~val | ~od);
      end
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         pin_out <= '0;
         pin_oe <= '0;
      end
      else
      begin
         pin_out <= out_nxt;
         pin_oe <= oe_nxt;
      end
   end

   // Unrouted peripheral inputs idle high
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         periph_in <= '1;
      else
         for (int s = 0; s < NSIG; s++)
            periph_in[s] <= sig_ok[s] ? pin_s2_r[sig_pin[s]] : 1'b1;
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   chk_drv_gate_off: assert property (!glob_en |=> pin_oe == '0)
      else $error("driver on while crossbar disabled");
   chk_rx_no_drive: assert property (
      sig_ok[xbar_pkg::S_SER0_RX] && !ser0_mode0
      |=> !pin_oe[$past(sig_pin[xbar_pkg::S_SER0_RX])])
      else $error("receive pin driven");
   chk_rmw_latch: assert property (
      bus.re && bus.rmw && bus.addr == xbar_pkg::OFF_PORT0
      |=> rdata == $past(lat_r[0]))
      else $error("rmw read did not return latch");
   chk_pin_read: assert property (
      bus.re && !bus.rmw && bus.addr == xbar_pkg::OFF_PORT0
      |=> rdata == $past(pin_s2_r[7:0]))
      else $error("port read not pin level");
   chk_od_release: assert property (
      glob_en && !pin_alloc[0] && !mode_r[0][0] && lat_r[0][0]
      |=> !pin_oe[0])
      else $error("open-drain high was driven");
   chk_pp_drive_high: assert property (
      glob_en && !pin_alloc[0] && mode_r[0][0] && lat_r[0][0]
      |=> pin_oe[0] && pin_out[0])
      else $error("push-pull high not driven");
   chk_serial_pair: assert property (
      sig_ok[xbar_pkg::S_SER0_TX] == sig_ok[xbar_pkg::S_SER0_RX])
      else $error("serial pins split");
   chk_first_pin: assert property (
      sig_ok[xbar_pkg::S_SER0_TX] |-> sig_pin[xbar_pkg::S_SER0_TX] == 5'h00)
      else $error("top priority not on first pin");
   chk_sel_3wire: assert property (
      !sig_en[xbar_pkg::S_SPI_SEL] |=> !sig_ok[xbar_pkg::S_SPI_SEL])
      else $error("slave select routed in 3-wire mode");
   chk_skip_pins: assert property (1'b1 |=> (pin_alloc & $past(skip)) == '0)
      else $error("skipped pin allocated");
   chk_bus_od: assert property (
      sig_ok[xbar_pkg::S_SMB_DAT]
      |=> !(pin_oe[$past(sig_pin[xbar_pkg::S_SMB_DAT])]
            && pin_out[$past(sig_pin[xbar_pkg::S_SMB_DAT])]))
      else $error("bus data pin driven high");
   chk_periph_value: assert property (
      sig_ok[xbar_pkg::S_CMP0]
      |=> pin_out[$past(sig_pin[xbar_pkg::S_CMP0])]
          == $past(periph_out[xbar_pkg::S_CMP0]))
      else $error("allocated pin not peripheral value");
endmodule
`default_nettype wire

// ===== design/xbar_pkg.sv
// Purpose: Constants, offsets and carriers for the crossbar and port block
// Assumes: 32 pins in four 8-bit ports, 32 routable peripheral signals
// Notes:   Overview of operation follows
`default_nettype none
package xbar_pkg;
   localparam int NPIN = 32;
   localparam int NSIG = 32;
   localparam int AW   = 4;
   // Register offsets
   localparam logic [3:0] OFF_ROUTE0 = 4'h0;
   localparam logic [3:0] OFF_ROUTE1 = 4'h1;
   localparam logic [3:0] OFF_ROUTE2 = 4'h2;
   localparam logic [3:0] OFF_ROUTE3 = 4'h3;
   localparam logic [3:0] OFF_PORT0  = 4'h4;
   localparam logic [3:0] OFF_MODE0  = 4'h8;
   localparam logic [3:0] OFF_DIN1   = 4'hC;
   localparam logic [3:0] OFF_DIN2   = 4'hD;
   // Reset values
   localparam logic [7:0] RST_ROUTE = 8'h00;
   localparam logic [7:0] RST_PORT  = 8'hFF;
   localparam logic [7:0] RST_MODE  = 8'h00;
   localparam logic [7:0] RST_DIN   = 8'hFF;
   // route_cfg_0 fields
   localparam int B_SMB_EN   = 0;
   localparam int B_SPI_EN   = 1;
   localparam int B_SER0_EN  = 2;
   localparam int B_PCA_LO   = 3;
   localparam int B_ECI_EN   = 6;
   localparam int B_CMP0_EN  = 7;
   // route_cfg_1 fields
   localparam int B_CMP1_EN  = 0;
   localparam int B_TM0_EN   = 1;
   localparam int B_IRQ0_EN  = 2;
   localparam int B_TM1_EN   = 3;
   localparam int B_IRQ1_EN  = 4;
   localparam int B_TM2_EN   = 5;
   localparam int B_TM2X_EN  = 6;
   localparam int B_CLKO_EN  = 7;
   // route_cfg_2 fields
   localparam int B_TM4X_EN  = 1;
   localparam int B_SER1_EN  = 2;
   localparam int B_TM4_EN   = 3;
   localparam int B_GLOB_EN  = 4;
   // route_cfg_3 fields
   localparam int B_TM3_EN   = 0;
   localparam int B_TM3X_EN  = 1;
   localparam int B_CNV_EN   = 2;
   localparam int B_CMP2_EN  = 3;
   localparam int B_SPI4W    = 4;
   // Peripheral signal indices, in priority order
   localparam int S_SER0_TX = 0;
   localparam int S_SER0_RX = 1;
   localparam int S_SPI_SCK = 2;
   localparam int S_SPI_MISO = 3;
   localparam int S_SPI_MOSI = 4;
   localparam int S_SPI_SEL = 5;
   localparam int S_SMB_DAT = 6;
   localparam int S_SMB_CLK = 7;
   localparam int S_SER1_TX = 8;
   localparam int S_SER1_RX = 9;
   localparam int S_PCA0    = 10;
   localparam int S_ECI     = 16;
   localparam int S_CMP0    = 17;
   localparam int S_CMP1    = 18;
   localparam int S_CMP2    = 19;
   localparam int S_TM0     = 20;
   localparam int S_IRQ0    = 21;
   localparam int S_TM1     = 22;
   localparam int S_IRQ1    = 23;
   localparam int S_TM2     = 24;
   localparam int S_TM2X    = 25;
   localparam int S_TM3     = 26;
   localparam int S_TM3X    = 27;
   localparam int S_TM4     = 28;
   localparam int S_TM4X    = 29;
   localparam int S_CLKO    = 30;
   localparam int S_CNV     = 31;
   // Signals that are inputs to a peripheral: not driven, except a receive pin in mode 0
   localparam logic [31:0] INPUT_ONLY = 32'hBFF1_0202;
   // Signals always open-drain
   localparam logic [31:0] FORCE_OD   = 32'h0000_00C0;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       we;
      logic       re;
      logic       rmw;
      logic       bit_we;
      logic [2:0] bit_sel;
   } bus_req_s;
endpackage
`default_nettype wire

// ===== design/pin_allocator.sv
// Purpose: Priority pin allocation from signal enables and skip mask
// Assumes: Inputs come from registers on the same clock
// Notes:   Tables are registered, so they lag the inputs by one edge
`default_nettype none
module pin_allocator #(
   parameter int NPIN = 32,
   parameter int NSIG = 32
) (
   // Clock and reset
   input  wire logic                  mclk,
   input  wire logic                  resetn,
   // Requests
   input  wire logic [NSIG-1:0]       sig_en,
   input  wire logic [NPIN-1:0]       skip,
   // Tables
   output logic      [NPIN-1:0]       pin_alloc,
   output logic [NPIN-1:0][4:0]       pin_sig,
   output logic      [NSIG-1:0]       sig_ok,
   output logic [NSIG-1:0][4:0]       sig_pin
);
   logic      [NPIN-1:0] alloc_nxt;
   logic [NPIN-1:0][4:0] psig_nxt;
   logic      [NSIG-1:0] ok_nxt;
   logic [NSIG-1:0][4:0] spin_nxt;

   // Walk signals by priority, each takes the next free non-skipped pin
   always_comb
   begin
      int  p;
      logic found;
      p = 0;
      found = 1'b0;
      alloc_nxt = '0;
      psig_nxt = '0;
      ok_nxt = '0;
      spin_nxt = '0;
      for (int s = 0; s < NSIG; s++)
      begin
         if (sig_en[s])
         begin
            found = 1'b0;
            for (int k = 0; k < NPIN; k++)
            begin
               if (!found && k >= p && !skip[k])
               begin
                  found = 1'b1;
                  alloc_nxt[k] = 1'b1;
                  psig_nxt[k] = 5'(s);
                  ok_nxt[s] = 1'b1;
                  spin_nxt[s] = 5'(k);
                  p = k + 1;
               end
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         pin_alloc <= '0;
         pin_sig <= '0;
         sig_ok <= '0;
         sig_pin <= '0;
      end
      else
      begin
         pin_alloc <= alloc_nxt;
         pin_sig <= psig_nxt;
         sig_ok <= ok_nxt;
         sig_pin <= spin_nxt;
      end
   end
endmodule
`default_nettype wire

// ===== verification/pin_board_model.sv
// Purpose: Board side of the port pins: weak pull-ups and optional external drivers
// Assumes: One external driver per pin, enabled bit by bit by the bench
// Notes:   A pin the device drives shows the device value; external drive loses
`default_nettype none
module pin_board_model (
   // Device side
   input  wire logic [31:0] pin_out,
   input  wire logic [31:0] pin_oe,
   // External drivers
   input  wire logic [31:0] ext_en,
   input  wire logic [31:0] ext_val,
   // Resolved level
   output logic      [31:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // Released pins without an external driver float up through the pull-up, so never an unknown level
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en);
endmodule
`default_nettype wire

// ===== verification/priority_crossbar_port_io_test.sv
// Purpose: Self-checking bench for the crossbar and port block
// Assumes: Latches FF and open-drain modes leave GPIO pins undriven
// Notes:   Routing is seen on pin_oe by holding one peripheral output low
`default_nettype none
module priority_crossbar_port_io_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic               mclk;
   logic               resetn;
   xbar_pkg::bus_req_s bus;
   logic [7:0]         rdata;
   logic [31:0]        periph_out;
   logic [31:0]        periph_oe;
   logic               ser0_mode0;
   logic               ser1_mode0;
   logic [31:0]        periph_in;
   logic [31:0]        pin_in;
   logic [31:0]        pin_out;
   logic [31:0]        pin_oe;
   logic [31:0]        ext_en;
   logic [31:0]        ext_val;
   logic [7:0]         v;
   int                 mismatches = 0;
   int                 check_count = 0;

   priority_crossbar_port_io DUT (
      .mclk       (mclk),
      .resetn     (resetn),
      .bus        (bus),
      .rdata      (rdata),
      .periph_out (periph_out),
      .periph_oe  (periph_oe),
      .ser0_mode0 (ser0_mode0),
      .ser1_mode0 (ser1_mode0),
      .periph_in  (periph_in),
      .pin_in     (pin_in),
      .pin_out    (pin_out),
      .pin_oe     (pin_oe)
   );

   pin_board_model board (
      .pin_out (pin_out),
      .pin_oe  (pin_oe),
      .ext_en  (ext_en),
      .ext_val (ext_val),
      .pin_in  (pin_in)
   );

   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task automatic report_and_stop;
      if (mismatches == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      bus.addr  <= a;
      bus.wdata <= d;
      bus.we    <= 1'b1;
      @(posedge mclk);
      bus.we    <= 1'b0;
   endtask

   task automatic wr_bit(input logic [3:0] a, input logic [2:0] b, input logic d);
      @(posedge mclk);
      bus.addr    <= a;
      bus.bit_sel <= b;
      bus.wdata   <= {7'h00, d};
      bus.bit_we  <= 1'b1;
      @(posedge mclk);
      bus.bit_we  <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic m, output logic [7:0] d);
      @(posedge mclk);
      bus.addr <= a;
      bus.rmw  <= m;
      bus.re   <= 1'b1;
      @(posedge mclk);
      bus.re   <= 1'b0;
      bus.rmw  <= 1'b0;
      @(negedge mclk);
      d = rdata;
   endtask

   // Table and driver registers, plus the first pin synchroniser stage
   task automatic settle;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
   endtask

   task automatic route(input logic [7:0] r0, input logic [7:0] r1, input logic [7:0] r2,
                        input logic [7:0] r3, input logic [31:0] po, input logic [31:0] exp);
      wr(xbar_pkg::OFF_ROUTE0, r0);
      wr(xbar_pkg::OFF_ROUTE1, r1);
      wr(xbar_pkg::OFF_ROUTE2, r2 | 8'h10);
      wr(xbar_pkg::OFF_ROUTE3, r3);
      periph_out <= po;
      settle;
      cmp_word(pin_oe, exp);
   endtask

   function automatic logic [31:0] low(input int s);
      return ~(32'h1 << s);
   endfunction

   function automatic logic [7:0] rst_val(input logic [3:0] a);
      if (a < 4'h4)
         return xbar_pkg::RST_ROUTE;
      if (a < 4'h8)
         return xbar_pkg::RST_PORT;
      if (a < 4'hC)
         return xbar_pkg::RST_MODE;
      if (a < 4'hE)
         return xbar_pkg::RST_DIN;
      return 8'h00;
   endfunction

   initial
   begin
      #2_000_000;
      mismatches++;
      report_and_stop;
   end

   initial
   begin
      bus = '0;
      resetn = 1'b0;
      periph_out = '1;
      periph_oe = '1;
      ser0_mode0 = 1'b0;
      ser1_mode0 = 1'b0;
      ext_en = '0;
      ext_val = '0;
      repeat (6) @(posedge mclk);
      resetn <= 1'b1;
      // Reset values, latches read back, unmapped places read zero
      wr(4'hE, 8'h5A);
      for (int a = 0; a < 16; a++)
      begin
         rd(a[3:0], 1'b1, v);
         cmp_byte(v, rst_val(a[3:0]));
      end
      // Drivers held off until the global enable
      wr(xbar_pkg::OFF_MODE0, 8'hFF);
      wr(xbar_pkg::OFF_PORT0, 8'h0F);
      settle;
      cmp_word(pin_oe, 32'h0);
      wr(xbar_pkg::OFF_ROUTE2, 8'h10);
      settle;
      cmp_word(pin_oe, 32'h0000_00FF);
      cmp_word(pin_out & pin_oe, 32'h0000_000F);
      wr(xbar_pkg::OFF_MODE0, 8'h33);
      settle;
      cmp_word(pin_oe, 32'h0000_00F3);
      cmp_word(pin_out & pin_oe, 32'h0000_0003);
      wr(xbar_pkg::OFF_MODE0, 8'h00);
      wr(xbar_pkg::OFF_PORT0, 8'hFF);
      // Pin level against latch contents
      ext_en <= 32'h0000_FF00;
      ext_val <= 32'h0000_A500;
      settle;
      rd(xbar_pkg::OFF_PORT0 + 4'h1, 1'b0, v);
      cmp_byte(v, 8'hA5);
      rd(xbar_pkg::OFF_PORT0 + 4'h1, 1'b1, v);
      cmp_byte(v, 8'hFF);
      wr_bit(xbar_pkg::OFF_PORT0 + 4'h1, 3'h3, 1'b0);
      rd(xbar_pkg::OFF_PORT0 + 4'h1, 1'b1, v);
      cmp_byte(v, 8'hF7);
      wr_bit(xbar_pkg::OFF_PORT0 + 4'h1, 3'h3, 1'b1);
      ext_en <= '0;
      // Routing and priority
      route(8'h04, 8'h00, 8'h00, 8'h00, low(xbar_pkg::S_SER0_TX), 32'h1);
      route(8'h04, 8'h00, 8'h00, 8'h00, low(xbar_pkg::S_SER0_RX), 32'h0);
      route(8'h05, 8'h00, 8'h00, 8'h00, low(xbar_pkg::S_SMB_DAT), 32'h4);
      route(8'h01, 8'h00, 8'h00, 8'h00, low(xbar_pkg::S_SMB_CLK), 32'h2);
      route(8'h06, 8'h00, 8'h00, 8'h00, low(xbar_pkg::S_SPI_SEL), 32'h0);
      route(8'h06, 8'h00, 8'h00, 8'h10, low(xbar_pkg::S_SPI_SEL), 32'h20);
      route(8'h06, 8'h00, 8'h00, 8'h00, low(xbar_pkg::S_SPI_MOSI), 32'h10);
      route(8'h00, 8'h00, 8'h00, 8'h00, low(xbar_pkg::S_CMP0), 32'h0);
      route(8'h85, 8'h00, 8'h00, 8'h00, low(xbar_pkg::S_CMP0), 32'h10);
      route(8'h07, 8'h00, 8'h04, 8'h10, low(xbar_pkg::S_SER1_TX), 32'h100);
      wr(xbar_pkg::OFF_DIN1, 8'hFE);
      route(8'h07, 8'h00, 8'h04, 8'h10, low(xbar_pkg::S_SER1_TX), 32'h200);
      wr(xbar_pkg::OFF_DIN1, 8'hFF);
      route(8'h07, 8'h00, 8'h04, 8'h10, low(xbar_pkg::S_SER1_TX), 32'h100);
      // Input signal routed to a pin, read back both ways
      ext_en <= 32'h1;
      ext_val <= 32'h0;
      route(8'h00, 8'h04, 8'h00, 8'h00, '1, 32'h0);
      cmp_word(periph_in & (32'h1 << xbar_pkg::S_IRQ0), 32'h0);
      rd(xbar_pkg::OFF_PORT0, 1'b0, v);
      cmp_byte(v, 8'hFE);
      route(8'h00, 8'h00, 8'h00, 8'h00, '1, 32'h0);
      cmp_word(periph_in & (32'h1 << xbar_pkg::S_IRQ0), 32'h1 << xbar_pkg::S_IRQ0);
      ext_en <= '0;
      // Push-pull modes on peripheral pins, forced open-drain on bus pins
      wr(xbar_pkg::OFF_MODE0, 8'hFF);
      route(8'h05, 8'h00, 8'h00, 8'h00, '1, 32'h0000_00F1);
      cmp_word(pin_out & pin_oe, 32'h0000_00F1);
      wr(xbar_pkg::OFF_PORT0, 8'h00);
      settle;
      cmp_word(pin_out & pin_oe, 32'h0000_0001);
      // Mode 0 receive pulls low only; timer inputs never drive
      @(posedge mclk);
      ser0_mode0 <= 1'b1;
      route(8'h04, 8'h00, 8'h00, 8'h00, '1, 32'h0000_00FD);
      route(8'h04, 8'h00, 8'h00, 8'h00, low(xbar_pkg::S_SER0_RX), 32'h0000_00FF);
      route(8'h00, 8'h08, 8'h00, 8'h00, low(xbar_pkg::S_TM1), 32'h0000_00FE);
      report_and_stop;
   end
endmodule
`default_nettype wire
